// ### common/ichp_pkg.sv
// Shared constants and types of the instrument command and data hub
package ichp_pkg;
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned REF_HZ          = 1_024_000;
  localparam int unsigned GND_CMD_BITS    = 27;
  localparam int unsigned OBC_CMD_BITS    = 16;
  localparam int unsigned SLOT_BITS       = 32;
  localparam int unsigned SLOTS_PER_CYCLE = 4;
  localparam int unsigned REPLY_BITS      = 9;
  localparam int unsigned ROM_REQS        = 64;
  localparam int unsigned DUMP_BANKS      = 16;
  localparam int unsigned DUMP_WORDS      = 4096;
  localparam int unsigned FRAME_BITS      = 16;
  localparam int unsigned PULSE_MS        = 35;
  // Divider half period for the forwarded reference clock, in sys cycles
  localparam int unsigned REF_HALF_CYC    = ((CLK_HZ / REF_HZ) / 2 > 0) ? (CLK_HZ / REF_HZ) / 2 : 1;
  // Discrete command pulse length in bus-clock ticks
  localparam int unsigned PULSE_TICKS     = (PULSE_MS * REF_HZ) / 1000;
  // Destination field: top bit of a command word, 1 = computer, 0 = bus
  localparam int unsigned DEST_POS_GND    = 26;
  localparam int unsigned DEST_POS_OBC    = 15;
  localparam logic        DEST_COMPUTER   = 1'b1;
  // Slot kind in bits 31:30 of command, request and idle slots; the sync slot sends SYNC_WORD
  localparam logic [1:0]  KIND_SYNC       = 2'h0;
  localparam logic [1:0]  KIND_CMD        = 2'h1;
  localparam logic [1:0]  KIND_REQ        = 2'h2;
  localparam logic [1:0]  KIND_IDLE       = 2'h3;
  localparam logic [31:0] SYNC_WORD       = 32'hA5A5_0000;
  localparam logic [5:0]  RM_ADDR_DEF     = 6'h01;
  typedef enum logic [1:0] {ICHP_DEST_BUS, ICHP_DEST_CPU} ichp_dest_t;
endpackage : ichp_pkg

// ### common/ichp_bus_if.sv
// Multiplexed instrument bus between hub and remote module
`timescale 1ns/1ps
`default_nettype none
interface ichp_bus_if;
  logic bus_clk;
  logic sup_data;
  logic sup_frame;
  logic rep_data;
  logic rep_valid;
  modport hub (output bus_clk, output sup_data, output sup_frame, input rep_data, input rep_valid);
  modport rm  (input bus_clk, input sup_data, input sup_frame, output rep_data, output rep_valid);
endinterface : ichp_bus_if
`default_nettype wire

// ### src/ichp_ser_rx.sv
// Enable, clock and data serial receiver with length check
`timescale 1ns/1ps
`default_nettype none
module ichp_ser_rx #(
  parameter int unsigned BITS = 16
) (
  input  wire logic            clk_sys,
  input  wire logic            resetn,
  input  wire logic            en_s,
  input  wire logic            clk_rise,
  input  wire logic            dat_s,
  output logic [BITS-1:0]      word,
  output logic                 word_vld
);
  logic [BITS-1:0] sh_r;
  logic [7:0]      cnt_r;
  logic            en_d_r;
  wire             en_fall = en_d_r & ~en_s;
  wire             len_ok  = (cnt_r == 8'(BITS));
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sh_r <= '0; cnt_r <= '0; en_d_r <= 1'b0; word_vld <= 1'b0; word <= '0;
    end else begin
      en_d_r   <= en_s;
      word_vld <= en_fall & len_ok; // RULE17
      if (en_fall) word <= sh_r;
      if (!en_s) cnt_r <= '0;
      else if (clk_rise) begin // RULE17
        sh_r  <= {sh_r[BITS-2:0], dat_s};
        cnt_r <= (cnt_r == 8'hff) ? cnt_r : cnt_r + 8'h01;
      end
    end
  end
endmodule : ichp_ser_rx
`default_nettype wire

// ### src/ichp_hub.sv
// Central format hub: command routing, supervisory bus and telemetry
// Functional notes
// RULE1: Forward 1.024 MHz reference, derive all timing
// RULE2: Timing pulse aligns framing and schedule
// RULE3: 27-bit ground commands received, routed onward
// RULE4: 16-bit onboard commands received, routed onward
// RULE5: Computer requests placed on supervisory bus
// RULE6: One reply collected per request issued
// RULE7: Minor frames shifted out on telemetry link
// RULE8: Abnormal mode: 64 ROM requests replace frames
// RULE9: Six-signal science input passed to computer; code passes sci_src 0 only
// RULE10: Packetise, optional randomise, continuous clock-data stream
// RULE11: Memory dump covers one 4096-word bank
// RULE12: Only addressed remote module answers
// RULE13: Module delivers serial or 35 ms discrete
// RULE14: Module returns 9-bit reply after sampling
// RULE15: Supervisory and reply buses at 1.024 MHz
// RULE16: Four repeating 32-bit supervisory slots
// RULE17: Shift only while enabled, drop wrong length
// RULE18: Destination field selects bus or computer
`timescale 1ns/1ps
`default_nettype none
module ichp_hub (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  ichp_bus_if.hub          bus,
  input  wire logic        ref_clk_in,
  input  wire logic        timing_pulse,
  input  wire logic        gnd_en,
  input  wire logic        gnd_clk,
  input  wire logic        gnd_dat,
  input  wire logic        obc_en,
  input  wire logic        obc_clk,
  input  wire logic        obc_dat,
  input  wire logic        abnormal,
  input  wire logic        req_vld,
  input  wire logic [31:0] req_word,
  output logic             req_rdy,
  output logic             reply_vld,
  output logic [8:0]       reply_word,
  output logic             cpu_cmd_vld,
  output logic [26:0]      cpu_cmd,
  input  wire logic        frame_vld,
  input  wire logic [15:0] frame_word,
  output logic             frame_rdy,
  output logic             tlm_en,
  output logic             tlm_clk,
  output logic             tlm_dat,
  input  wire logic        sci_vld,
  input  wire logic [7:0]  sci_byte,
  input  wire logic [1:0]  sci_src,
  input  wire logic        pn_on,
  output logic             sci_to_cpu_vld,
  output logic [7:0]       sci_to_cpu,
  output logic             sd_clk,
  output logic             sd_dat
);
  // ==========================================================
  // Input synchronisers
  logic [1:0] s1_r, s2_r, s3_r, s4_r, s5_r, s6_r, s7_r, s8_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_r <= '0; s2_r <= '0; s3_r <= '0; s4_r <= '0; s5_r <= '0; s6_r <= '0; s7_r <= '0; s8_r <= '0;
    end else begin
      s1_r <= {s1_r[0], ref_clk_in}; s2_r <= {s2_r[0], timing_pulse};
      s3_r <= {s3_r[0], gnd_en};     s4_r <= {s4_r[0], gnd_clk};
      s5_r <= {s5_r[0], gnd_dat};    s6_r <= {s6_r[0], obc_en};
      s7_r <= {s7_r[0], obc_clk};    s8_r <= {s8_r[0], obc_dat};
    end
  end
  logic ref_d_r, tp_d_r, gc_d_r, oc_d_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ref_d_r <= 1'b0; tp_d_r <= 1'b0; gc_d_r <= 1'b0; oc_d_r <= 1'b0;
    end else begin
      ref_d_r <= s1_r[1]; tp_d_r <= s2_r[1]; gc_d_r <= s4_r[1]; oc_d_r <= s7_r[1];
    end
  end
  wire ref_rise = s1_r[1] & ~ref_d_r;
  wire ref_fall = ~s1_r[1] & ref_d_r;
  wire tp_rise  = s2_r[1] & ~tp_d_r;
  wire gc_rise  = s4_r[1] & ~gc_d_r;
  wire oc_rise  = s7_r[1] & ~oc_d_r;

  // ==========================================================
  // Command receivers and routing
  logic [26:0] gword;
  logic [15:0] oword;
  logic        gvld, ovld;
  ichp_ser_rx #(.BITS(ichp_pkg::GND_CMD_BITS)) u_gnd (
    .clk_sys(clk_sys), .resetn(resetn), .en_s(s3_r[1]), .clk_rise(gc_rise), .dat_s(s5_r[1]),
    .word(gword), .word_vld(gvld)); // RULE3
  ichp_ser_rx #(.BITS(ichp_pkg::OBC_CMD_BITS)) u_obc (
    .clk_sys(clk_sys), .resetn(resetn), .en_s(s6_r[1]), .clk_rise(oc_rise), .dat_s(s8_r[1]),
    .word(oword), .word_vld(ovld)); // RULE4
  wire g_cpu = gword[ichp_pkg::DEST_POS_GND] == ichp_pkg::DEST_COMPUTER; // RULE18
  wire o_cpu = oword[ichp_pkg::DEST_POS_OBC] == ichp_pkg::DEST_COMPUTER; // RULE18
  logic        cmd_pend_r;
  logic [31:0] cmd_slot_r;
  logic        slot_tick;
  logic [1:0]  slot_idx_r;
  wire         cmd_taken = slot_tick & (slot_idx_r == 2'd1) & cmd_pend_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cpu_cmd_vld <= 1'b0; cpu_cmd <= '0; cmd_pend_r <= 1'b0; cmd_slot_r <= '0;
    end else begin
      cpu_cmd_vld <= (gvld & g_cpu) | (ovld & o_cpu);
      if (gvld & g_cpu) cpu_cmd <= {1'b0, gword[25:0]}; // RULE3
      else if (ovld & o_cpu) cpu_cmd <= {12'h000, oword[14:0]}; // RULE4
      if (gvld & ~g_cpu) begin
        cmd_pend_r <= 1'b1; cmd_slot_r <= {ichp_pkg::KIND_CMD, 4'h0, gword[25:0]};
      end else if (ovld & ~o_cpu) begin
        cmd_pend_r <= 1'b1; cmd_slot_r <= {ichp_pkg::KIND_CMD, 15'h0000, oword[14:0]};
      end else if (cmd_taken) cmd_pend_r <= 1'b0;
    end
  end

  // ==========================================================
  // Supervisory bus slot engine
  localparam logic [5:0] ROM_LAST = 6'(ichp_pkg::ROM_REQS - 1);
  logic [4:0]  bit_r;
  logic [31:0] sh_r;
  logic        req_hold_r, await_r;
  logic [31:0] req_hold_w_r;
  logic [5:0]  rom_idx_r;
  assign slot_tick = ref_fall & (bit_r == 5'd31);
  wire [31:0] rom_req = {ichp_pkg::KIND_REQ, 18'h00000, 6'h01, rom_idx_r}; // RULE8
  wire [1:0]  nxt_idx = slot_idx_r + 2'd1;
  wire        req_slot = (nxt_idx == 2'd2) & slot_tick;
  wire        can_req  = abnormal ? 1'b1 : req_hold_r;
  wire [31:0] nxt_word = (nxt_idx == 2'd0) ? ichp_pkg::SYNC_WORD :
                         (nxt_idx == 2'd1 & cmd_pend_r) ? cmd_slot_r :
                         (nxt_idx == 2'd2 & can_req & ~await_r) ? (abnormal ? rom_req : req_hold_w_r) :
                         {ichp_pkg::KIND_IDLE, 30'h0000_0000};
  wire issue = req_slot & can_req & ~await_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bit_r <= '0; slot_idx_r <= '0; sh_r <= ichp_pkg::SYNC_WORD; rom_idx_r <= '0;
      bus.bus_clk <= 1'b0; bus.sup_data <= 1'b0; bus.sup_frame <= 1'b0;
    end else begin
      bus.bus_clk <= s1_r[1]; // RULE1 RULE15
      if (tp_rise) begin // RULE2
        bit_r <= '0; slot_idx_r <= '0; sh_r <= ichp_pkg::SYNC_WORD;
      end else if (ref_fall) begin
        bus.sup_data  <= sh_r[31]; // RULE16
        bus.sup_frame <= (bit_r == 5'd0);
        bit_r <= bit_r + 5'd1;
        if (bit_r == 5'd31) begin
          slot_idx_r <= nxt_idx; // RULE16
          sh_r       <= nxt_word;
          if (issue & abnormal) rom_idx_r <= (rom_idx_r == ROM_LAST) ? 6'h00 : rom_idx_r + 6'h01;
        end else sh_r <= {sh_r[30:0], 1'b0};
      end
    end
  end
  // Request holding register from the computer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      req_hold_r <= 1'b0; req_hold_w_r <= '0; req_rdy <= 1'b0;
    end else begin
      req_rdy <= ~req_hold_r & ~req_rdy;
      if (req_vld & req_rdy) begin // RULE5
        req_hold_r <= 1'b1; req_hold_w_r <= {ichp_pkg::KIND_REQ, req_word[29:0]};
      end else if (issue & ~abnormal) req_hold_r <= 1'b0;
    end
  end

  // ==========================================================
  // Reply collection, one per issued request
  logic [3:0] rcnt_r;
  logic [8:0] rsh_r;
  logic       rv_d_r;
  logic [1:0] rv_s_r, rd_s_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rcnt_r <= '0; rsh_r <= '0; await_r <= 1'b0; reply_vld <= 1'b0; reply_word <= '0;
      rv_s_r <= '0; rd_s_r <= '0; rv_d_r <= 1'b0;
    end else begin
      rv_s_r <= {rv_s_r[0], bus.rep_valid}; rd_s_r <= {rd_s_r[0], bus.rep_data};
      rv_d_r <= rv_s_r[1];
      reply_vld <= 1'b0;
      if (issue) await_r <= 1'b1; // RULE6
      if (await_r & ref_rise & rv_s_r[1]) begin
        rsh_r  <= {rsh_r[7:0], rd_s_r[1]};
        rcnt_r <= rcnt_r + 4'd1;
      end
      if (await_r & rv_d_r & ~rv_s_r[1]) begin // RULE6
        await_r <= 1'b0; rcnt_r <= '0;
        reply_vld  <= ~abnormal & (rcnt_r == 4'(ichp_pkg::REPLY_BITS));
        reply_word <= rsh_r;
      end
    end
  end

  // ==========================================================
  // Telemetry shifter: frames or ROM replies
  logic [15:0] tsh_r;
  logic [4:0]  tcnt_r;
  logic        tl_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tsh_r <= '0; tcnt_r <= '0; tlm_en <= 1'b0; tlm_clk <= 1'b0; tlm_dat <= 1'b0; frame_rdy <= 1'b0;
      tl_r <= 1'b0;
    end else begin
      frame_rdy <= (tcnt_r == 5'd0) & ~abnormal & ~frame_rdy;
      if (tcnt_r == 5'd0) begin
        tlm_en <= 1'b0; tlm_clk <= 1'b0; tl_r <= 1'b0;
        if (frame_vld & frame_rdy & ~abnormal) begin // RULE7
          tsh_r <= frame_word; tcnt_r <= 5'(ichp_pkg::FRAME_BITS);
        end else if (abnormal & await_r & rv_d_r & ~rv_s_r[1]) begin // RULE8
          tsh_r <= {7'h00, rsh_r}; tcnt_r <= 5'(ichp_pkg::FRAME_BITS);
        end
      end else begin
        tlm_en <= 1'b1;
        if (ref_fall) begin
          tlm_clk <= 1'b0; tlm_dat <= tsh_r[15]; tl_r <= 1'b1;
        end else if (ref_rise & tl_r) begin
          tlm_clk <= 1'b1; tsh_r <= {tsh_r[14:0], 1'b0}; tcnt_r <= tcnt_r - 5'd1; tl_r <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Science path: source-0 passthrough and continuous stream with PN option
  logic [7:0] ssh_r, pn_r;
  logic [2:0] sbit_r;
  logic       have_r;
  logic [7:0] nxt_r;
  wire        pn_fb = pn_r[7] ^ pn_r[5] ^ pn_r[4] ^ pn_r[3];
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ssh_r <= '0; pn_r <= 8'hff; sbit_r <= '0; have_r <= 1'b0; nxt_r <= '0;
      sd_clk <= 1'b0; sd_dat <= 1'b0; sci_to_cpu_vld <= 1'b0; sci_to_cpu <= '0;
    end else begin
      sci_to_cpu_vld <= sci_vld & (sci_src == 2'd0); // RULE9
      if (sci_vld) sci_to_cpu <= sci_byte;
      if (sci_vld) begin
        have_r <= 1'b1; nxt_r <= sci_byte; // RULE10 RULE11
      end
      sd_clk <= s1_r[1];
      if (ref_fall) begin
        sd_dat <= ssh_r[7] ^ (pn_on & pn_r[7]); // RULE10
        pn_r   <= {pn_r[6:0], pn_fb};
        sbit_r <= sbit_r + 3'd1;
        if (sbit_r == 3'd7) begin
          ssh_r  <= have_r ? nxt_r : 8'h00;
          have_r <= sci_vld;
          if (pn_on & ~have_r) pn_r <= 8'hff;
        end else ssh_r <= {ssh_r[6:0], 1'b0};
      end
    end
  end
endmodule : ichp_hub
`default_nettype wire

// ### src/ichp_rm.sv
// Remote module end of the multiplexed instrument bus
`timescale 1ns/1ps
`default_nettype none
module ichp_rm (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  ichp_bus_if.rm           bus,
  input  wire logic [5:0]  my_addr,
  input  wire logic [7:0]  sample,
  output logic             cmd_vld,
  output logic [15:0]      cmd_word,
  output logic             discrete_out
);
  logic [1:0]  ck_s_r, d_s_r, f_s_r;
  logic        ck_d_r;
  logic [31:0] sh_r;
  logic [5:0]  cnt_r;
  logic [8:0]  rep_r;
  logic [3:0]  rcnt_r;
  logic [15:0] pulse_r;
  wire rise = ck_s_r[1] & ~ck_d_r;
  wire fall = ~ck_s_r[1] & ck_d_r;
  wire [31:0] w = {sh_r[30:0], d_s_r[1]};
  wire done = rise & (cnt_r == 6'd31);
  wire mine = w[11:6] == my_addr; // RULE12
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ck_s_r <= '0; d_s_r <= '0; f_s_r <= '0; ck_d_r <= 1'b0; sh_r <= '0; cnt_r <= '0;
      rep_r <= '0; rcnt_r <= '0; pulse_r <= '0; cmd_vld <= 1'b0; cmd_word <= '0;
      discrete_out <= 1'b0; bus.rep_data <= 1'b0; bus.rep_valid <= 1'b0;
    end else begin
      ck_s_r <= {ck_s_r[0], bus.bus_clk}; d_s_r <= {d_s_r[0], bus.sup_data};
      f_s_r <= {f_s_r[0], bus.sup_frame}; ck_d_r <= ck_s_r[1];
      cmd_vld <= 1'b0;
      if (rise) begin
        sh_r  <= w;
        cnt_r <= f_s_r[1] ? 6'd1 : cnt_r + 6'd1;
      end
      if (done & w[31:30] == ichp_pkg::KIND_CMD) begin // RULE13
        cmd_vld <= 1'b1; cmd_word <= w[15:0];
        if (w[15]) pulse_r <= 16'(ichp_pkg::PULSE_TICKS);
      end
      if (done & w[31:30] == ichp_pkg::KIND_REQ & mine) begin // RULE14
        rep_r <= {^sample, sample}; rcnt_r <= 4'(ichp_pkg::REPLY_BITS);
      end
      if (rise & pulse_r != 16'h0000) pulse_r <= pulse_r - 16'h0001;
      discrete_out <= pulse_r != 16'h0000;
      if (fall) begin
        bus.rep_valid <= rcnt_r != 4'd0;
        bus.rep_data  <= rep_r[8];
        if (rcnt_r != 4'd0) begin
          rep_r <= {rep_r[7:0], 1'b0}; rcnt_r <= rcnt_r - 4'd1;
        end
      end
    end
  end
endmodule : ichp_rm
`default_nettype wire

// ### bench/ichp_bus_assertions.sv
// Checker of supervisory and reply bus timing
`timescale 1ns/1ps
`default_nettype none
module ichp_bus_assertions (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic bus_clk,
  input wire logic sup_data,
  input wire logic sup_frame,
  input wire logic rep_data,
  input wire logic rep_valid
);
  logic        bclk_q, frm_q, rv_q, seen, done_q, sync_ok;
  logic [5:0]  cnt, rcnt;
  logic [6:0]  still;
  logic [1:0]  idx;
  logic [2:0]  pend;
  logic [31:0] sh;
  wire         rise_b  = bus_clk & ~bclk_q;
  wire         frm_up  = sup_frame & ~frm_q;
  wire         rep_end = rv_q & ~rep_valid;
  wire [1:0]   kind    = sh[31:30];
  wire         is_sync = (sh == ichp_pkg::SYNC_WORD) | (kind == ichp_pkg::KIND_SYNC);
  wire         is_req  = done_q & ~is_sync & (kind == ichp_pkg::KIND_REQ);
  wire         chk_at  = done_q & sync_ok;
  // ==========================================
  // Bit counters and slot capture
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {bclk_q, frm_q, rv_q, seen, done_q, sync_ok} <= 6'h00;
      {cnt, rcnt, still, idx, pend} <= 24'h00_0000;
      sh <= 32'h0000_0000;
    end else begin
      bclk_q  <= bus_clk;
      frm_q   <= sup_frame;
      rv_q    <= rep_valid;
      seen    <= seen | frm_up;
      done_q  <= seen & rise_b & (cnt == 6'h1F);
      cnt     <= frm_up ? 6'h00 : cnt + {5'h00, rise_b};
      rcnt    <= (rep_valid & ~rv_q) ? {5'h00, rise_b} : rcnt + {5'h00, rise_b & rep_valid};
      still   <= (bus_clk != bclk_q) ? 7'h00 : still + {6'h00, ~&still};
      sh      <= rise_b ? {sh[30:0], sup_data} : sh;
      sync_ok <= sync_ok | (done_q & is_sync);
      idx     <= done_q ? (is_sync ? 2'h0 : idx + 2'h1) : idx;
      pend    <= pend + {2'h0, is_req} - {2'h0, rep_end};
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  slot_period_a: assert property (frm_up && seen |-> cnt == 6'h20)
    else $error("slot length wrong");
  sync_slot_a: assert property (chk_at && idx == 2'h3 |-> is_sync)
    else $error("sync slot missing");
  cmd_slot_a: assert property (chk_at && idx == 2'h0 |-> kind != ichp_pkg::KIND_REQ)
    else $error("slot one kind wrong");
  req_slot_a: assert property (chk_at && idx == 2'h1 |-> kind[1])
    else $error("slot two kind wrong");
  idle_slot_a: assert property (chk_at && idx == 2'h2 |-> kind == ichp_pkg::KIND_IDLE)
    else $error("slot three not idle");
  reply_len_a: assert property (rep_end |-> rcnt == 6'h09)
    else $error("reply not 9 bits");
  reply_pair_a: assert property (rep_end |-> pend != 3'h0)
    else $error("reply without request");
  bus_run_a: assert property (still < 7'h64)
    else $error("bus clock stopped");
  sup_launch_a: assert property ($changed(sup_data) |-> !bus_clk)
    else $error("supervisory bit moved while clock high");
endmodule : ichp_bus_assertions
`default_nettype wire

// ### bench/ichp_hub_tb.sv
// Bench joining hub and remote module over the instrument bus
`timescale 1ns/1ps
`default_nettype none
module ichp_hub_tb;
  logic        clk_sys, resetn, ref_clk_in, timing_pulse, abnormal, pn_on, s_en, s_clk, s_dat, to_gnd;
  logic        req_vld, frame_vld, sci_vld, req_rdy, reply_vld, cpu_cmd_vld, frame_rdy, last_sd;
  logic        tlm_en, tlm_clk, tlm_dat, sci_to_cpu_vld, sd_clk, rm_cmd_vld;
  logic [15:0] rm_cmd_word;
  logic [31:0] req_word;
  logic [26:0] cpu_cmd;
  logic [15:0] frame_word, w;
  logic [8:0]  reply_word;
  logic [7:0]  sci_byte, sci_to_cpu, sample;
  logic [1:0]  sci_src;
  int          err_count, compares, toggles;
  wire         gnd_en  = s_en & to_gnd;
  wire         gnd_clk = s_clk & to_gnd;
  wire         obc_en  = s_en & ~to_gnd;
  wire         obc_clk = s_clk & ~to_gnd;
  ichp_bus_if ichp_bus_if_i ();
  ichp_hub ichp_hub_i (.clk_sys, .resetn, .bus(ichp_bus_if_i.hub), .ref_clk_in, .timing_pulse, .gnd_en, .gnd_clk,
    .gnd_dat(s_dat), .obc_en, .obc_clk, .obc_dat(s_dat), .abnormal, .req_vld, .req_word, .req_rdy, .reply_vld,
    .reply_word, .cpu_cmd_vld, .cpu_cmd, .frame_vld, .frame_word, .frame_rdy, .tlm_en, .tlm_clk, .tlm_dat,
    .sci_vld, .sci_byte, .sci_src, .pn_on, .sci_to_cpu_vld, .sci_to_cpu, .sd_clk, .sd_dat());
  ichp_rm ichp_rm_i (.clk_sys, .resetn, .bus(ichp_bus_if_i.rm), .my_addr(ichp_pkg::RM_ADDR_DEF), .sample,
    .cmd_vld(rm_cmd_vld), .cmd_word(rm_cmd_word), .discrete_out());
  ichp_bus_assertions ichp_bus_assertions_i (.clk_sys, .resetn, .bus_clk(ichp_bus_if_i.bus_clk),
    .sup_data(ichp_bus_if_i.sup_data), .sup_frame(ichp_bus_if_i.sup_frame), .rep_data(ichp_bus_if_i.rep_data),
    .rep_valid(ichp_bus_if_i.rep_valid));
  // ==========================================
  // Clocks, tasks and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    ref_clk_in = 1'b0;
    #7;
    forever #160 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    wrap_up();
  end
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cycles
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic send_cmd(input logic gnd, input logic [26:0] word, input int n);
    to_gnd = gnd;
    s_en = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      s_dat = word[i];
      cycles(4);
      s_clk = 1'b1;
      cycles(4);
      s_clk = 1'b0;
    end
    cycles(2);
    s_en = 1'b0;
    s_dat = ~s_dat;
  endtask : send_cmd
  task automatic wait_on(input int which, input int lim, input logic exp);
    logic [4:0] v;
    logic       hit;
    hit = 1'b0;
    for (int n = 0; n < lim && !hit; n++) begin
      v = {rm_cmd_vld, tlm_en, sci_to_cpu_vld, reply_vld, cpu_cmd_vld};
      hit = v[which] === 1'b1;
      if (!hit) @(negedge clk_sys);
    end
    chk("pulse seen", {31'h0, exp}, {31'h0, hit});
  endtask : wait_on
  task automatic offer(input logic is_frame);
    int n;
    n = 0;
    frame_vld = is_frame;
    req_vld = ~is_frame;
    while ((is_frame ? frame_rdy : req_rdy) !== 1'b1 && n < 9000) begin
      @(negedge clk_sys);
      n++;
    end
    chk("ready seen", 32'h0000_0001, {31'h0, n < 9000});
    @(negedge clk_sys);
    {frame_vld, req_vld} = 2'h0;
  endtask : offer
  task automatic get_tlm(output logic [15:0] word);
    logic last;
    word = 16'h0000;
    last = 1'b1;
    wait_on(3, 9000, 1'b1);
    for (int n = 0; n < 3000 && tlm_en === 1'b1; n++) begin
      if (tlm_clk === 1'b1 && last === 1'b0) word = {word[14:0], tlm_dat};
      last = tlm_clk;
      @(negedge clk_sys);
    end
  endtask : get_tlm
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // ==========================================
  // Tests
  initial begin
    {resetn, timing_pulse, abnormal, pn_on, s_en, s_clk, s_dat, to_gnd} = 8'h00;
    {req_vld, frame_vld, sci_vld, sci_src, last_sd} = 6'h00;
    {req_word, frame_word, sci_byte} = 56'h00_0000_0000_0000;
    sample = 8'h5A;
    cycles(2);
    resetn = 1'b1;
    cycles(3);
    timing_pulse = 1'b1;
    cycles(1);
    timing_pulse = 1'b0;
    send_cmd(1'b1, 27'h4AB_CDEF, 27);
    wait_on(0, 50, 1'b1);
    chk("ground command", 32'h00AB_CDEF, {5'h00, cpu_cmd});
    send_cmd(1'b0, 27'h000_9A5C, 16);
    wait_on(0, 50, 1'b1);
    chk("onboard command", 32'h0000_1A5C, {16'h0000, cpu_cmd[15:0]});
    send_cmd(1'b1, 27'h000_1234, 27);
    wait_on(4, 2500, 1'b1);
    chk("bus command", 32'h0000_1234, {16'h0000, rm_cmd_word});
    send_cmd(1'b1, 27'h7FF_FFFF, 26);
    wait_on(0, 60, 1'b0);
    $display("command links done");
    {sci_src, sci_byte, pn_on, sci_vld} = 12'h25B;
    cycles(1);
    sci_vld = 1'b0;
    wait_on(2, 50, 1'b1);
    chk("science byte", 32'h0000_0096, {24'h00_0000, sci_to_cpu});
    for (int n = 0; n < 400; n++) begin
      toggles += (sd_clk !== last_sd);
      last_sd = sd_clk;
      @(negedge clk_sys);
    end
    chk("stream clock moving", 32'h0000_0001, {31'h0, toggles > 0});
    $display("science path done");
    for (int k = 0; k < 2; k++) begin
      sample = k ? 8'hA5 : 8'h5A;
      req_word = {ichp_pkg::KIND_REQ, 18'h0_0000, ichp_pkg::RM_ADDR_DEF, 6'h00};
      offer(1'b0);
      wait_on(1, 9000, 1'b1);
      chk("reply data", {24'h00_0000, sample}, {24'h00_0000, reply_word[7:0]});
    end
    $display("requests done");
    frame_word = 16'hC3A1;
    offer(1'b1);
    get_tlm(w);
    chk("telemetry frame", 32'h0000_C3A1, {16'h0000, w});
    abnormal = 1'b1;
    get_tlm(w);
    chk("fixed request reply", {24'h00_0000, sample}, {24'h00_0000, w[7:0]});
    abnormal = 1'b0;
    $display("telemetry done");
    req_word = {ichp_pkg::KIND_REQ, 18'h0_0000, 6'h02, 6'h00};
    offer(1'b0);
    wait_on(1, 8000, 1'b0);
    $display("foreign address done");
    wrap_up();
  end
endmodule : ichp_hub_tb
`default_nettype wire
